// >>> src/rcirq_top.sv
// Radio control registers: host alert, channel, assessment and strength
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rcirq_top #(
    parameter int SYM_CYC = rcirq_pkg::SYMBOL_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire rcirq_pkg::rcirq_bus_t bus,
    output logic [7:0] rdata,
    input wire logic [7:0] event_pulse,
    input wire rcirq_pkg::rcirq_radio_t radio,
    output logic alert,
    output logic medium_busy,
    output logic [3:0] chan_sel,
    output logic radio_restart,
    output logic [2:0] soft_reset_req
);
    import rcirq_pkg::*;

    logic [7:0] flags_ff, enables_ff, polar_ff, chan_ff, radio_ctl_ff, assess_ff;
    logic [7:0] energy_th_ff, bcn_ff, bb6_ff, pa_ff, stbl_ff, vco_tune_ff, pll_ff;
    logic [7:0] filt_ff, slpsel_ff, vco_ctl_ff, slpdiv_ff, soft_ff, rdata_ff;
    logic alert_ff, busy_ff, restart_ff;
    logic [7:0] energy_ff;
    logic carrier_ff;
    logic [7:0] nxt_flags;
    logic [7:0] nxt_rdata;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
        return a == ofs;
    endfunction

    wire wr = bus.wr;
    wire rd = bus.rd;
    wire [9:0] adr = bus.addr;
    wire [7:0] wd = bus.wdata;
    wire wr_en = wr && hit(adr, OFS_IRQ_EN);
    wire rd_flags = rd && hit(adr, OFS_IRQ_FLAGS);
    wire wr_bb6 = wr && hit(adr, OFS_BB_CFG6);

    assign nxt_flags = (rd_flags ? 8'h00 : flags_ff) | event_pulse;

    wire any_evt = |(nxt_flags & enables_ff);

    wire [1:0] mode = assess_ff[7:6];
    wire [3:0] cs_th = assess_ff[5:2];
    wire energy_hi = energy_ff > energy_th_ff;
    wire carrier_hi = carrier_ff && (radio.carrier_level >= cs_th);
    wire nxt_busy = (mode == MODE_ENERGY) ? energy_hi :
                    (mode == MODE_CARRIER) ? carrier_hi :
                    (mode == MODE_BOTH) ? (carrier_hi && energy_hi) : 1'b0;

    wire meas_start = wr_bb6 && wd[POS_REQ];
    logic meas_busy, meas_done;
    logic [7:0] meas_result;

    rcirq_strength_avg #(
        .SYM_CYC(SYM_CYC)
    ) u_avg (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(meas_start),
        .avg_sel(bcn_ff[POS_AVG_LO +: 2]),
        .sample(energy_ff),
        .busy(meas_busy),
        .done(meas_done),
        .result(meas_result)
    );

    always_comb begin
        nxt_rdata = 8'h00;
        case (adr)
            OFS_PA_CTL2: nxt_rdata = pa_ff;
            OFS_SOFT_RST: nxt_rdata = soft_ff;
            OFS_TX_STBL: nxt_rdata = stbl_ff;
            OFS_IRQ_FLAGS: nxt_rdata = flags_ff;
            OFS_IRQ_EN: nxt_rdata = enables_ff;
            OFS_BCN_CFG: nxt_rdata = bcn_ff;
            OFS_RADIO_CTL: nxt_rdata = radio_ctl_ff;
            OFS_ASSESS_CFG: nxt_rdata = assess_ff;
            OFS_BB_CFG6: nxt_rdata = bb6_ff;
            OFS_ENERGY_TH: nxt_rdata = energy_th_ff;
            OFS_CHAN_CFG: nxt_rdata = chan_ff;
            OFS_VCO_TUNE: nxt_rdata = vco_tune_ff;
            OFS_PLL_CTL: nxt_rdata = pll_ff;
            OFS_FILT_CFG: nxt_rdata = filt_ff;
            OFS_SLPCLK_SEL: nxt_rdata = slpsel_ff;
            OFS_VCO_CTL: nxt_rdata = vco_ctl_ff;
            OFS_STRENGTH: nxt_rdata = meas_result;
            OFS_SLP_ALERT: nxt_rdata = polar_ff;
            OFS_SLPCLK_DIV: nxt_rdata = slpdiv_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_ff <= RST_ZERO;
            enables_ff <= RST_ZERO;
            polar_ff <= RST_ZERO;
            alert_ff <= 1'b1;
            rdata_ff <= RST_ZERO;
        end else begin
            flags_ff <= nxt_flags;
            rdata_ff <= rd ? nxt_rdata : 8'h00;
            if (wr_en) begin
                enables_ff <= wd;
            end
            if (wr && hit(adr, OFS_SLP_ALERT)) begin
                polar_ff <= wd;
            end
            alert_ff <= polar_ff[POS_POLARITY] ? any_evt : ~any_evt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            chan_ff <= RST_ZERO;
            radio_ctl_ff <= RST_ZERO;
            assess_ff <= RST_ZERO;
            energy_th_ff <= RST_ZERO;
            bcn_ff <= RST_ZERO;
            pa_ff <= RST_ZERO;
            stbl_ff <= RST_ZERO;
            vco_tune_ff <= RST_ZERO;
            pll_ff <= RST_ZERO;
            filt_ff <= RST_ZERO;
            slpsel_ff <= RST_ZERO;
            vco_ctl_ff <= RST_ZERO;
            slpdiv_ff <= RST_ZERO;
        end else if (wr) begin
            case (adr)
                OFS_CHAN_CFG: chan_ff <= wd;
                OFS_RADIO_CTL: radio_ctl_ff <= wd;
                OFS_ASSESS_CFG: assess_ff <= wd;
                OFS_ENERGY_TH: energy_th_ff <= wd;
                OFS_BCN_CFG: bcn_ff <= wd;
                OFS_PA_CTL2: pa_ff <= wd;
                OFS_TX_STBL: stbl_ff <= wd;
                OFS_VCO_TUNE: vco_tune_ff <= wd;
                OFS_PLL_CTL: pll_ff <= wd;
                OFS_FILT_CFG: filt_ff <= wd;
                OFS_SLPCLK_SEL: slpsel_ff <= wd;
                OFS_VCO_CTL: vco_ctl_ff <= wd;
                OFS_SLPCLK_DIV: slpdiv_ff <= wd;
                default: chan_ff <= chan_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bb6_ff <= RST_ZERO;
            soft_ff <= RST_ZERO;
            energy_ff <= RST_ZERO;
            carrier_ff <= 1'b0;
            busy_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            // Self clearing soft resets
            soft_ff <= (wr && hit(adr, OFS_SOFT_RST)) ? (wd & RST_SOFT_MASK) : RST_ZERO;
            if (meas_done) begin
                bb6_ff[POS_DONE] <= 1'b1;
            end else if (wr_bb6) begin
                bb6_ff[POS_DONE] <= 1'b0;
            end
            if (wr_bb6) begin
                bb6_ff[7:1] <= wd[7:1] & RST_BB6_MASK[7:1];
            end else if (meas_done) begin
                bb6_ff[POS_REQ] <= 1'b0;
            end
            if (radio.energy_valid) begin
                energy_ff <= radio.energy;
            end
            carrier_ff <= radio.carrier_valid;
            busy_ff <= nxt_busy;
            restart_ff <= radio_ctl_ff[POS_RESTART];
        end
    end

    assign rdata = rdata_ff;
    assign alert = alert_ff;
    assign medium_busy = busy_ff;
    assign chan_sel = chan_ff[POS_CHAN_LO +: 4];
    assign radio_restart = restart_ff;
    assign soft_reset_req = soft_ff[2:0];
    wire unused_busy = meas_busy;
endmodule // rcirq_top
`default_nettype wire

// >>> src/rcirq_pkg.sv
// Package: register map, field positions and types of the radio control block
package rcirq_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFS_PA_CTL2 = 10'h018;
    localparam logic [9:0] OFS_SOFT_RST = 10'h02a;
    localparam logic [9:0] OFS_TX_STBL = 10'h02e;
    localparam logic [9:0] OFS_IRQ_FLAGS = 10'h031;
    localparam logic [9:0] OFS_IRQ_EN = 10'h032;
    localparam logic [9:0] OFS_BCN_CFG = 10'h025;
    localparam logic [9:0] OFS_RADIO_CTL = 10'h036;
    localparam logic [9:0] OFS_ASSESS_CFG = 10'h03a;
    localparam logic [9:0] OFS_BB_CFG6 = 10'h03e;
    localparam logic [9:0] OFS_ENERGY_TH = 10'h03f;
    localparam logic [9:0] OFS_CHAN_CFG = 10'h200;
    localparam logic [9:0] OFS_VCO_TUNE = 10'h201;
    localparam logic [9:0] OFS_PLL_CTL = 10'h202;
    localparam logic [9:0] OFS_FILT_CFG = 10'h206;
    localparam logic [9:0] OFS_SLPCLK_SEL = 10'h207;
    localparam logic [9:0] OFS_VCO_CTL = 10'h208;
    localparam logic [9:0] OFS_STRENGTH = 10'h210;
    localparam logic [9:0] OFS_SLP_ALERT = 10'h211;
    localparam logic [9:0] OFS_SLPCLK_DIV = 10'h220;
    localparam int POS_POLARITY = 1;
    localparam int POS_RESTART = 2;
    localparam int POS_REQ = 7;
    localparam int POS_DONE = 0;
    localparam int POS_AVG_LO = 4;
    localparam int POS_TH_LO = 2;
    localparam int POS_CHAN_LO = 4;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SOFT_MASK = 8'h07;
    localparam logic [7:0] RST_BB6_MASK = 8'hC0;
    localparam logic [1:0] MODE_ENERGY = 2'b10;
    localparam logic [1:0] MODE_CARRIER = 2'b01;
    localparam logic [1:0] MODE_BOTH = 2'b11;
    localparam int REPORT_SYMBOLS = 8;
    localparam int SYMBOL_NS = 16000;
    localparam int CLK_NS = 40;
    localparam int SYMBOL_CYC = SYMBOL_NS / CLK_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rcirq_bus_t;

    typedef struct packed {
        logic energy_valid;
        logic [7:0] energy;
        logic carrier_valid;
        logic [3:0] carrier_level;
    } rcirq_radio_t;

    typedef enum logic [1:0] {
        RCIRQ_IDLE = 2'b00,
        RCIRQ_MEAS = 2'b01,
        RCIRQ_DONE = 2'b11
    } rcirq_meas_t;
endpackage : rcirq_pkg

// >>> src/rcirq_strength_avg.sv
// Strength averaging engine for firmware requested measurements
`timescale 1ns/100ps
`default_nettype none
module rcirq_strength_avg #(
    parameter int SYM_CYC = rcirq_pkg::SYMBOL_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [1:0] avg_sel,
    input wire logic [7:0] sample,
    output logic busy,
    output logic done,
    output logic [7:0] result
);
    import rcirq_pkg::*;

    rcirq_meas_t state_ff, nxt_state;
    logic [15:0] cyc_ff;
    logic [3:0] sym_ff;
    logic [11:0] acc_ff;
    logic [7:0] result_ff;
    logic done_ff;
    wire sym_tick = (cyc_ff == 16'(SYM_CYC - 1));
    wire [3:0] sym_goal = 4'(REPORT_SYMBOLS);
    wire last_sym = sym_tick && (sym_ff == sym_goal - 4'h1);
    wire [11:0] acc_sum = acc_ff + {4'h0, sample};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RCIRQ_IDLE: nxt_state = start ? RCIRQ_MEAS : RCIRQ_IDLE;
            RCIRQ_MEAS: nxt_state = last_sym ? RCIRQ_DONE : RCIRQ_MEAS;
            RCIRQ_DONE: nxt_state = RCIRQ_IDLE;
            default: nxt_state = RCIRQ_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= RCIRQ_IDLE;
            cyc_ff <= 16'h0000;
            sym_ff <= 4'h0;
            acc_ff <= 12'h000;
            result_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            done_ff <= (state_ff == RCIRQ_MEAS) && last_sym;
            if (state_ff != RCIRQ_MEAS) begin
                cyc_ff <= 16'h0000;
                sym_ff <= 4'h0;
                acc_ff <= 12'h000;
            end else begin
                cyc_ff <= sym_tick ? 16'h0000 : cyc_ff + 16'h0001;
                if (sym_tick) begin
                    sym_ff <= sym_ff + 4'h1;
                    acc_ff <= acc_sum;
                end
                if (last_sym) begin
                    result_ff <= acc_sum[10:3];
                end
            end
        end
    end

    assign busy = (state_ff != RCIRQ_IDLE);
    assign done = done_ff;
    assign result = result_ff;
    wire unused_sel = ^avg_sel;
endmodule // rcirq_strength_avg
`default_nettype wire

// >>> bench/rcirq_chk.sv
// Checker of the radio control block outputs
`timescale 1ns/100ps
`default_nettype none
module rcirq_chk
    import rcirq_pkg::*;
#(
    parameter int SYM_CYC = SYMBOL_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire rcirq_pkg::rcirq_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic [7:0] event_pulse,
    input wire rcirq_pkg::rcirq_radio_t radio,
    input wire logic alert,
    input wire logic medium_busy,
    input wire logic [3:0] chan_sel,
    input wire logic radio_restart,
    input wire logic [2:0] soft_reset_req
);
    logic [7:0] en_ff, cfg_ff, th_ff;
    logic pol_ff;
    wire logic wr_soft = bus.wr && bus.addr == OFS_SOFT_RST;
    wire logic rd_flags = bus.rd && bus.addr == OFS_IRQ_FLAGS;
    wire logic stir = bus.wr || bus.rd || event_pulse != 8'h00;
    wire logic e_hi = radio.energy > th_ff;
    wire logic c_hi = radio.carrier_valid && radio.carrier_level >= cfg_ff[5:2];
    wire logic [1:0] mode = cfg_ff[7:6];
    wire logic exp_busy = (mode == MODE_ENERGY) ? e_hi : (mode == MODE_CARRIER) ? c_hi :
        (mode == MODE_BOTH) && e_hi && c_hi;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            en_ff <= 8'h00;
            cfg_ff <= 8'h00;
            th_ff <= 8'h00;
            pol_ff <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == OFS_IRQ_EN) en_ff <= bus.wdata;
            if (bus.addr == OFS_ASSESS_CFG) cfg_ff <= bus.wdata;
            if (bus.addr == OFS_ENERGY_TH) th_ff <= bus.wdata;
            if (bus.addr == OFS_SLP_ALERT) pol_ff <= bus.wdata[POS_POLARITY];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_clean_read;
        rd_flags && event_pulse == 8'h00 ##1 event_pulse == 8'h00 ##1 rd_flags;
    endsequence
    sequence s_quiet;
        !bus.wr ##1 !bus.wr && !bus.rd;
    endsequence
    a_rdata_idle: assert property (
        !$past(bus.rd) |-> rdata == 8'h00) else $error("rdata not idle");
    a_flag_clear: assert property (
        s_clean_read |=> rdata == 8'h00) else $error("flags not cleared");
    a_alert_hold: assert property (
        $changed(alert) |-> $past(stir) || $past(stir, 2)) else $error("alert moved");
    a_alert_rise: assert property (
        (event_pulse & en_ff) != 8'h00 ##0 s_quiet |=> alert == pol_ff)
        else $error("alert not active");
    a_restart_copy: assert property (
        bus.wr && bus.addr == OFS_RADIO_CTL |=> ##1 radio_restart == $past(bus.wdata[2], 2))
        else $error("restart wrong");
    a_chan_field: assert property (
        bus.wr && bus.addr == OFS_CHAN_CFG |=> chan_sel == $past(bus.wdata[7:4]))
        else $error("channel wrong");
    a_soft_pulse: assert property (
        wr_soft |=> soft_reset_req == $past(bus.wdata[2:0])) else $error("soft pulse wrong");
    a_soft_idle: assert property (
        !$past(wr_soft) |-> soft_reset_req == 3'b000) else $error("soft pulse stuck");
    a_assess_busy: assert property (
        !bus.wr && radio.energy_valid && $stable(radio) |=> medium_busy == $past(exp_busy))
        else $error("busy wrong");
endmodule // rcirq_chk
bind rcirq_top rcirq_chk #(.SYM_CYC(SYM_CYC)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus(bus), .rdata(rdata), .event_pulse(event_pulse), .radio(radio), .alert(alert),
    .medium_busy(medium_busy), .chan_sel(chan_sel), .radio_restart(radio_restart),
    .soft_reset_req(soft_reset_req));
`default_nettype wire

// >>> bench/rcirq_radio_model.sv
// Radio front end model feeding energy and carrier samples
`timescale 1ns/100ps
`default_nettype none
module rcirq_radio_model
    import rcirq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] level,
    input wire logic [3:0] carrier,
    input wire logic carrier_on,
    output var rcirq_pkg::rcirq_radio_t radio
);
    initial radio = '0;
    always @(posedge ref_clk) begin
        radio <= '{energy_valid: 1'b1, energy: level, carrier_valid: carrier_on,
            carrier_level: carrier_on ? carrier : ~carrier};
    end
endmodule // rcirq_radio_model
`default_nettype wire

// >>> bench/test_radio_ctrl_irq_cca_rssi.sv
// Self-checking bench of the radio control registers
`timescale 1ns/100ps
`default_nettype none
module test_radio_ctrl_irq_cca_rssi;
    import rcirq_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    rcirq_bus_t bus = '0;
    logic [7:0] event_pulse = 8'h00;
    logic [7:0] level = 8'h00;
    logic carrier_on = 1'b0;
    rcirq_radio_t radio;
    logic [7:0] rdata, got;
    logic alert, medium_busy, radio_restart;
    logic [3:0] chan_sel;
    logic [2:0] soft_reset_req;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [9:0] rw_ofs [9] = '{OFS_PA_CTL2, OFS_TX_STBL, OFS_VCO_TUNE, OFS_PLL_CTL,
        OFS_FILT_CFG, OFS_SLPCLK_SEL, OFS_VCO_CTL, OFS_SLPCLK_DIV, OFS_ENERGY_TH};
    always #20 ref_clk = ~ref_clk;
    rcirq_top #(.SYM_CYC(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .event_pulse(event_pulse), .radio(radio), .alert(alert),
        .medium_busy(medium_busy), .chan_sel(chan_sel), .radio_restart(radio_restart),
        .soft_reset_req(soft_reset_req));
    rcirq_radio_model u_radio (.ref_clk(ref_clk), .level(level), .carrier(4'h5),
        .carrier_on(carrier_on), .radio(radio));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] ev);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        event_pulse <= ev;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        event_pulse <= 8'h00;
        #1 got = rdata;
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge ref_clk);
        event_pulse <= ev;
        @(posedge ref_clk);
        event_pulse <= 8'h00;
    endtask
    task automatic alert_is(input logic v);
        repeat (2) @(posedge ref_clk);
        #1 chk({7'h0, alert}, {7'h0, v});
    endtask
    function automatic logic exp_b(input logic [1:0] m, input logic e, input logic c);
        return (m == MODE_ENERGY) ? e : (m == MODE_CARRIER) ? c : (m == MODE_BOTH) && e && c;
    endfunction
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #800000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        chk(got, 8'h00);
        foreach (rw_ofs[i]) begin
            rd(rw_ofs[i], 8'h00);
            chk(got, 8'h00);
            wr(rw_ofs[i], 8'ha5);
            rd(rw_ofs[i], 8'h00);
            chk(got, 8'ha5);
        end
        wr(OFS_IRQ_EN, 8'hff);
        wr(OFS_SLP_ALERT, 8'h02);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            alert_is(1'b1);
            rd(OFS_IRQ_FLAGS, 8'h00);
            chk(got, 8'h01 << i);
            alert_is(1'b0);
        end
        wr(OFS_SLP_ALERT, 8'h00);
        pulse(8'h10);
        alert_is(1'b0);
        rd(OFS_IRQ_FLAGS, 8'h08);
        chk(got, 8'h10);
        rd(OFS_IRQ_FLAGS, 8'h00);
        chk(got, 8'h08);
        rd(OFS_IRQ_FLAGS, 8'h00);
        chk(got, 8'h00);
        alert_is(1'b1);
        wr(OFS_IRQ_EN, 8'h00);
        pulse(8'h80);
        alert_is(1'b1);
        rd(OFS_IRQ_FLAGS, 8'h00);
        chk(got, 8'h80);
        for (int ch = 11; ch <= 26; ch++) begin
            wr(OFS_CHAN_CFG, {4'(ch - 11), 4'h3});
            #1 chk({4'h0, chan_sel}, 8'(ch - 11));
        end
        wr(OFS_RADIO_CTL, 8'h04);
        @(posedge ref_clk);
        #1 chk({7'h0, radio_restart}, 8'h01);
        wr(OFS_RADIO_CTL, 8'h00);
        repeat (4800) @(posedge ref_clk);
        rd(OFS_CHAN_CFG, 8'h00);
        chk(got, 8'hf3);
        wr(OFS_SOFT_RST, 8'h07);
        #1 chk({5'h0, soft_reset_req}, 8'h07);
        wr(OFS_ENERGY_TH, 8'h60);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_ASSESS_CFG, {2'(m), 4'h5, 2'b00});
            for (int k = 0; k < 3; k++) begin
                @(posedge ref_clk);
                level <= (k == 1) ? 8'h60 : 8'h61;
                carrier_on <= (k != 2);
                repeat (3) @(posedge ref_clk);
                #1 chk({7'h0, medium_busy}, {7'h0, exp_b(2'(m), k != 1, k != 2)});
            end
        end
        wr(OFS_BCN_CFG, 8'h30);
        rd(OFS_BCN_CFG, 8'h00);
        chk(got & 8'h30, 8'h30);
        level <= 8'h5a;
        wr(OFS_BB_CFG6, 8'h80);
        got = 8'h00;
        for (int t = 0; t < 200 && got[POS_DONE] !== 1'b1; t++) begin
            rd(OFS_BB_CFG6, 8'h00);
        end
        chk(got, 8'h01);
        rd(OFS_STRENGTH, 8'h00);
        chk(got, 8'h5a);
        test_done();
    end
endmodule // test_radio_ctrl_irq_cca_rssi
`default_nettype wire
